// file: hdl/gp_regs.svh
`ifndef GP_REGS_SVH
`define GP_REGS_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define GP_IDX_PA_DATA 8'h05
`define GP_IDX_PB_DATA 8'h06
`define GP_IDX_IRQ_CTL 8'h0B
`define GP_IDX_OPTION  8'h81
`define GP_IDX_PA_DIR  8'h85
`define GP_IDX_PB_DIR  8'h86

// ****************************************
// field positions
// ****************************************
`define GP_OPT_PU_DIS_BIT 7
`define GP_IRQ_FLAG_BIT   0
`define GP_IRQ_EN_BIT     3

// ****************************************
// reset values
// ****************************************
`define GP_PA_DIR_RST 5'h1F
`define GP_PB_DIR_RST 8'hFF
`define GP_OPTION_RST 8'hFF
`define GP_PA_LAT_RST 5'h00
`define GP_PB_LAT_RST 8'h00
`define GP_IRQ_RST    8'h00
`endif

// file: hdl/gp_pkg.sv
package gp_pkg;

   // ****************************************
   // register select
   // ****************************************
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_PA_DATA,
      SEL_PA_DIR,
      SEL_PB_DATA,
      SEL_PB_DIR,
      SEL_OPTION,
      SEL_IRQ_CTL
   } gp_sel_e;

   // ****************************************
   // whole block state
   // ****************************************
   typedef struct packed {
      logic [4:0] pa_lat;
      logic [4:0] pa_dir;
      logic [7:0] pb_lat;
      logic [7:0] pb_dir;
      logic [7:0] option;
      logic [7:1] irq_hi;
      logic       flag;
      logic [3:0] snap;
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic       dp_wr;
      gp_sel_e    dp_sel;
      logic [7:0] rdata;
   } gp_state_s;

endpackage

// file: hdl/gp_port.sv
`timescale 1ns/1ps
`include "gp_regs.svh"
module gp_port (
   // clock, reset, enable
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // first port pins
   input  wire logic [4:0]  pa_in,
   output logic      [4:0]  pa_out,
   output logic      [4:0]  pa_oe_n,
   output logic             pin4_timer_clock_in,
   // second port pins
   input  wire logic [7:0]  pb_in,
   output logic      [7:0]  pb_out,
   output logic      [7:0]  pb_oe_n,
   output logic      [7:0]  pb_pullup_en,
   // change detect
   output logic             port_change_flag,
   output logic             wake_req
);

   // ****************************************
   // functions
   // ****************************************

   // address to register select
   function automatic gp_pkg::gp_sel_e decode(
      input logic [31:0] a,
      input logic [2:0]  sz
   );
      gp_pkg::gp_sel_e s;
      s = gp_pkg::SEL_NONE;
      if ((a[31:10] == 22'h000000) && (a[1:0] == 2'h0) &&
          (sz == 3'h2)) begin
         unique case (a[9:2])
            `GP_IDX_PA_DATA: s = gp_pkg::SEL_PA_DATA;
            `GP_IDX_PA_DIR:  s = gp_pkg::SEL_PA_DIR;
            `GP_IDX_PB_DATA: s = gp_pkg::SEL_PB_DATA;
            `GP_IDX_PB_DIR:  s = gp_pkg::SEL_PB_DIR;
            `GP_IDX_OPTION:  s = gp_pkg::SEL_OPTION;
            `GP_IDX_IRQ_CTL: s = gp_pkg::SEL_IRQ_CTL;
            default:         s = gp_pkg::SEL_NONE;
         endcase
      end
      return s;
   endfunction

   // read value of a register
   function automatic logic [7:0] rd_value(
      input gp_pkg::gp_sel_e   s,
      input gp_pkg::gp_state_s q,
      input logic [4:0]        pa,
      input logic [7:0]        pb
   );
      logic [7:0] v;
      v = 8'h00;
      unique case (s)
         gp_pkg::SEL_PA_DATA: v = {3'h0, pa};
         gp_pkg::SEL_PA_DIR:  v = {3'h0, q.pa_dir};
         gp_pkg::SEL_PB_DATA: v = pb;
         gp_pkg::SEL_PB_DIR:  v = q.pb_dir;
         gp_pkg::SEL_OPTION:  v = q.option;
         gp_pkg::SEL_IRQ_CTL: v = {q.irq_hi, q.flag};
         gp_pkg::SEL_NONE:    v = 8'h00;
      endcase
      return v;
   endfunction

   // ****************************************
   // state
   // ****************************************
   localparam gp_pkg::gp_state_s ST_RST = '{
      pa_lat: `GP_PA_LAT_RST,
      pa_dir: `GP_PA_DIR_RST,
      pb_lat: `GP_PB_LAT_RST,
      pb_dir: `GP_PB_DIR_RST,
      option: `GP_OPTION_RST,
      irq_hi: 7'h00,
      flag:   1'b0,
      snap:   4'h0,
      sync1:  4'h0,
      sync2:  4'h0,
      dp_wr:  1'b0,
      dp_sel: gp_pkg::SEL_NONE,
      rdata:  8'h00
   };

   gp_pkg::gp_state_s st_reg;
   gp_pkg::gp_state_s st_next;
   gp_pkg::gp_sel_e   addr_sel;
   logic              take;
   logic              mismatch;

   // address phase accepted
   assign take     = hsel & htrans[1] & hready & ce;
   assign addr_sel = decode(haddr, hsize);

   // input pins that differ from snapshot
   assign mismatch = |((st_reg.sync2 ^ st_reg.snap)
                       & st_reg.pb_dir[7:4]);

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_next = st_reg;
      // two-stage sync of monitored pins
      st_next.sync1 = pb_in[7:4];
      st_next.sync2 = st_reg.sync1;
      st_next.dp_wr = 1'b0;
      // address phase: capture read data
      if (take) begin
         st_next.dp_sel = addr_sel;
         st_next.dp_wr  = hwrite & (addr_sel != gp_pkg::SEL_NONE);
         if (!hwrite) begin
            st_next.rdata = rd_value(addr_sel, st_reg, pa_in, pb_in);
            if (addr_sel == gp_pkg::SEL_PB_DATA) begin
               st_next.snap = st_reg.sync2;
            end
         end
      end
      // data phase: commit write at cycle end
      if (st_reg.dp_wr) begin
         unique case (st_reg.dp_sel)
            gp_pkg::SEL_PA_DATA: st_next.pa_lat = hwdata[4:0];
            gp_pkg::SEL_PA_DIR:  st_next.pa_dir = hwdata[4:0];
            gp_pkg::SEL_PB_DATA: begin
               st_next.pb_lat = hwdata[7:0];
               st_next.snap   = st_reg.sync2;
            end
            gp_pkg::SEL_PB_DIR:  st_next.pb_dir = hwdata[7:0];
            gp_pkg::SEL_OPTION:  st_next.option = hwdata[7:0];
            gp_pkg::SEL_IRQ_CTL: begin
               st_next.irq_hi = hwdata[7:1];
               st_next.flag   = hwdata[`GP_IRQ_FLAG_BIT];
            end
            gp_pkg::SEL_NONE:    st_next.dp_wr = 1'b0;
         endcase
      end
      // hardware set wins over software clear
      if (mismatch) begin
         st_next.flag = 1'b1;
      end
   end

   // register the state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= ST_RST;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************

   // bus answer, zero wait unless frozen
   assign hrdata    = {24'h000000, st_reg.rdata};
   assign hreadyout = ce;
   assign hresp     = 1'b0;

   // first port: low bits push-pull, bit 4 open drain
   assign pa_out     = {1'b0, st_reg.pa_lat[3:0]};
   assign pa_oe_n[3:0] = st_reg.pa_dir[3:0];
   assign pa_oe_n[4] = st_reg.pa_dir[4] | st_reg.pa_lat[4];
   assign pin4_timer_clock_in = pa_in[4];

   // second port and pull-ups
   assign pb_out  = st_reg.pb_lat;
   assign pb_oe_n = st_reg.pb_dir;
   assign pb_pullup_en = {8{~st_reg.option[`GP_OPT_PU_DIS_BIT]}}
                         & st_reg.pb_dir;

   // change flag and wake
   assign port_change_flag = st_reg.flag;
   assign wake_req = st_reg.flag & st_reg.irq_hi[`GP_IRQ_EN_BIT];

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   chk_pa_upper_zero: assert property (
      take && !hwrite && (addr_sel == gp_pkg::SEL_PA_DATA ||
                          addr_sel == gp_pkg::SEL_PA_DIR)
      |=> hrdata[31:5] == 27'h0000000)
      else $error("upper port bits not zero");

   chk_pin4_opendrain: assert property (
      pa_out[4] == 1'b0 && (pa_oe_n[4] || !st_reg.pa_lat[4]))
      else $error("pin 4 drives high");

   chk_dir_write: assert property (
      ce && st_reg.dp_wr && st_reg.dp_sel == gp_pkg::SEL_PA_DIR
      |=> pa_oe_n[3:0] == $past(hwdata[3:0]))
      else $error("direction write not applied");

   chk_read_pins: assert property (
      take && !hwrite && addr_sel == gp_pkg::SEL_PB_DATA
      |=> hrdata[7:0] == $past(pb_in))
      else $error("read does not return pins");

   chk_write_latch: assert property (
      ce && st_reg.dp_wr && st_reg.dp_sel == gp_pkg::SEL_PB_DATA
      |=> pb_out == $past(hwdata[7:0]))
      else $error("write did not reach latch");

   chk_pullup_output: assert property (
      (pb_pullup_en & ~pb_oe_n) == 8'h00)
      else $error("pull-up on output pin");

   chk_reset_dirs: assert property (
      $rose(hresetn) |-> pa_oe_n == 5'h1F && pb_oe_n == 8'hFF &&
                         pb_pullup_en == 8'h00)
      else $error("reset directions wrong");

   chk_output_excl: assert property (
      st_reg.pb_dir[7:4] == 4'h0 |-> !mismatch)
      else $error("output pin caused mismatch");

   chk_flag_set: assert property (
      ce && mismatch |=> port_change_flag)
      else $error("mismatch did not set flag");

   chk_wake_flag: assert property (
      ce && mismatch && st_reg.irq_hi[`GP_IRQ_EN_BIT]
      |=> wake_req)
      else $error("wake not raised");

   chk_sync_path: assert property (
      $past(ce) && $past(ce, 2) && $past(hresetn, 2)
      |-> st_reg.sync2 == $past(pb_in[7:4], 2))
      else $error("sync delay wrong");

   // ****************************************
   // bus answer checks
   // ****************************************

   // ready follows the enable, no wait otherwise
   chk_ready_ce: assert property (
      hreadyout == ce)
      else $error("ready does not follow enable");

   // every answer is okay
   chk_resp_okay: assert property (
      hresp == 1'b0)
      else $error("response not okay");

   // only the low byte ever carries data
   chk_rdata_byte: assert property (
      hrdata[31:8] == 24'h000000)
      else $error("read data upper bits set");

   // unmapped reads return zero
   chk_unmapped_read: assert property (
      take && !hwrite && addr_sel == gp_pkg::SEL_NONE
      |=> hrdata == 32'h00000000)
      else $error("unmapped read not zero");

   // direction read returns stored bits
   chk_pa_dir_read: assert property (
      take && !hwrite && addr_sel == gp_pkg::SEL_PA_DIR
      |=> hrdata[4:0] == $past(st_reg.pa_dir))
      else $error("direction read wrong");

   // ****************************************
   // first port checks
   // ****************************************

   // data write lands in the five-bit latch
   chk_pa_latch_write: assert property (
      ce && st_reg.dp_wr && st_reg.dp_sel == gp_pkg::SEL_PA_DATA
      |=> st_reg.pa_lat == $past(hwdata[4:0]))
      else $error("first port latch not written");

   // push-pull bits drive the latch
   chk_pa_drive: assert property (
      pa_out[3:0] == st_reg.pa_lat[3:0])
      else $error("first port drive wrong");

   // timer clock taps pin 4
   chk_timer_clock: assert property (
      pin4_timer_clock_in == pa_in[4])
      else $error("timer clock not pin 4");

   // ****************************************
   // second port checks
   // ****************************************

   // output enables follow direction bits
   chk_pb_oe: assert property (
      pb_oe_n == st_reg.pb_dir)
      else $error("second port enable wrong");

   // direction write reaches the pins
   chk_pb_dir_write: assert property (
      ce && st_reg.dp_wr && st_reg.dp_sel == gp_pkg::SEL_PB_DIR
      |=> pb_oe_n == $past(hwdata[7:0]))
      else $error("second direction not written");

   // option write is stored
   chk_opt_write: assert property (
      ce && st_reg.dp_wr && st_reg.dp_sel == gp_pkg::SEL_OPTION
      |=> st_reg.option == $past(hwdata[7:0]))
      else $error("option not written");

   // disable bit set keeps all pull-ups off
   chk_pullup_global: assert property (
      st_reg.option[`GP_OPT_PU_DIS_BIT] |-> pb_pullup_en == 8'h00)
      else $error("pull-up on while disabled");

   // ****************************************
   // change detect checks
   // ****************************************

   // a second port data read recaptures the snapshot
   chk_snap_read: assert property (
      take && !hwrite && addr_sel == gp_pkg::SEL_PB_DATA
      |=> st_reg.snap == $past(st_reg.sync2))
      else $error("snapshot not recaptured");

   // flag holds until software writes the control register
   chk_flag_hold: assert property (
      ce && port_change_flag &&
      !(st_reg.dp_wr && st_reg.dp_sel == gp_pkg::SEL_IRQ_CTL)
      |=> port_change_flag)
      else $error("flag dropped without clear");

   // clear works once the mismatch has ended
   chk_flag_clear: assert property (
      ce && st_reg.dp_wr && st_reg.dp_sel == gp_pkg::SEL_IRQ_CTL &&
      !hwdata[`GP_IRQ_FLAG_BIT] && !mismatch
      |=> !port_change_flag)
      else $error("flag clear ignored");

   // no wake without the change enable
   chk_wake_off: assert property (
      !st_reg.irq_hi[`GP_IRQ_EN_BIT] |-> !wake_req)
      else $error("wake without enable");

   // ****************************************
   // clock enable checks
   // ****************************************

   // enable low freezes all state
   chk_ce_freeze: assert property (
      !ce |=> $stable(st_reg))
      else $error("state moved while frozen");

   cov_change_flag: cover property (ce && mismatch ##1 port_change_flag);
   cov_pb_read: cover property (take && !hwrite &&
                                addr_sel == gp_pkg::SEL_PB_DATA);
   cov_flag_clear: cover property (port_change_flag ##1 !port_change_flag);
   cov_wake: cover property (!wake_req ##1 wake_req);
   cov_pb_write: cover property (ce && st_reg.dp_wr &&
                                 st_reg.dp_sel == gp_pkg::SEL_PB_DATA);

endmodule

// file: bench/gp_pins_model.sv
`timescale 1ns/1ps
module gp_pins_model (
   // clock
   input  wire logic       hclk,
   // block side
   input  wire logic [4:0] pa_out,
   input  wire logic [4:0] pa_oe_n,
   input  wire logic [7:0] pb_out,
   input  wire logic [7:0] pb_oe_n,
   input  wire logic [7:0] pb_pullup_en,
   // keypad side
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   // resolved levels
   output logic      [4:0] pa_in,
   output logic      [7:0] pb_in
);
   // a released line with no pull settles low on this board
   logic wob;
   assign wob = 1'b0;

   // first port: bit 4 open drain with board pull-up
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         pa_in[i] = !pa_oe_n[i] ? pa_out[i] : ((i == 4) ? 1'b1 : wob);
      end
   end

   // second port: driver, keypad, weak pull-up, else float
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pb_oe_n[i]) begin
            pb_in[i] = pb_out[i];
         end else if (ext_en[i]) begin
            pb_in[i] = ext_val[i];
         end else begin
            pb_in[i] = pb_pullup_en[i] ? 1'b1 : wob;
         end
      end
   end
endmodule

// file: bench/gp_port_tb.sv
`timescale 1ns/1ps
module gp_port_tb;
   logic        hclk, hresetn, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hreadyout, hresp, tclk, flag, wake, ce;
   logic [4:0]  pa_in, pa_out, pa_oe_n;
   logic [7:0]  pb_in, pb_out, pb_oe_n, pu_en, ext_en, ext_val;
   int          err_count, check_count, cyc;

   gp_port gp_port_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pin4_timer_clock_in(tclk),
      .pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pb_pullup_en(pu_en),
      .port_change_flag(flag), .wake_req(wake));
   gp_pins_model gp_pins_model_i (.hclk(hclk), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
      .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pb_pullup_en(pu_en), .ext_en(ext_en),
      .ext_val(ext_val), .pa_in(pa_in), .pb_in(pb_in));

   // clock and hang guard
   initial hclk = 1'b0;
   always #20 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         conclude();
      end
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      @(negedge hclk);
   endtask

   task automatic conclude();
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      bus(0, 32'h214, 0); chk(q, 32'h1F);
      bus(0, 32'h218, 0); chk(q, 32'hFF);
      bus(0, 32'h204, 0); chk(q, 32'hFF);
      bus(0, 32'h02C, 0); chk(q, 32'h00);
      chk(pa_oe_n, 5'h1F);
      chk(pu_en, 8'h00);
      bus(0, 32'h3F0, 0); chk(q, 32'h00);
   endtask

   task automatic t_port_a();
      bus(1, 32'h214, 32'hE0); bus(0, 32'h214, 0); chk(q, 32'h00);
      bus(1, 32'h014, 32'hFF);
      chk(pa_out, 5'h0F);
      chk(pa_oe_n, 5'h10);
      bus(0, 32'h014, 0); chk(q, 32'h1F);
      bus(1, 32'h014, 32'h0A);
      chk(pa_oe_n, 5'h00);
      bus(0, 32'h014, 0); chk(q, 32'h0A);
      chk(tclk, 1'b0);
      bus(1, 32'h214, 32'h05); bus(0, 32'h014, 0); chk(q[3:1], 3'h5);
   endtask

   task automatic t_port_b();
      bus(1, 32'h204, 32'h7F); bus(1, 32'h218, 32'hF8); bus(1, 32'h018, 32'h5A);
      chk(pu_en, 8'hF8);
      chk(pb_oe_n, 8'hF8);
      chk(pb_out, 8'h5A);
      bus(0, 32'h018, 0); chk(q, 32'hFA);
      bus(1, 32'h02C, 32'h00); chk(hresp, 1'b0);
      chk(flag, 1'b0);
      ext_en <= 8'h08; ext_val <= 8'h00;
      repeat (6) @(negedge hclk);
      chk(flag, 1'b0);
      ext_en <= 8'h28;
      repeat (6) @(negedge hclk);
      chk(flag, 1'b1);
      chk(wake, 1'b0);
      bus(1, 32'h02C, 32'h08);
      chk(flag, 1'b1);
      chk(wake, 1'b1);
      bus(0, 32'h018, 0); chk(q, 32'hD2);
      repeat (3) @(negedge hclk);
      bus(1, 32'h02C, 32'h08);
      @(negedge hclk);
      chk(flag, 1'b0);
      @(posedge hclk);
      ce <= 1'b0; ext_en <= 8'h08;
      repeat (6) @(negedge hclk);
      chk(flag, 1'b0);
      chk(hreadyout, 1'b0);
      @(posedge hclk);
      ce <= 1'b1;
      repeat (6) @(negedge hclk);
      chk(flag, 1'b1);
   endtask

   // main sequence
   initial begin
      {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
      {ext_en, ext_val, err_count, check_count, cyc} = '0;
      ce = 1'b1;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_port_a();
      t_port_b();
      conclude();
   end
endmodule
